// ===== hw/tw_pkg.sv
// constants, register map and types of the three-wire serial channel
package tw_pkg;

    // register indices; byte address is four times the index
    localparam logic [15:0] TW_IDX_MODE   = 16'hff60;
    localparam logic [15:0] TW_IDX_BUSCTL = 16'hff61;
    localparam logic [15:0] TW_IDX_SHIFT  = 16'hff62;
    localparam logic [15:0] TW_IDX_AUX    = 16'hff63;
    localparam logic [31:0] TW_ADDR_MODE   = {14'h0000, TW_IDX_MODE, 2'h0};
    localparam logic [31:0] TW_ADDR_BUSCTL = {14'h0000, TW_IDX_BUSCTL, 2'h0};
    localparam logic [31:0] TW_ADDR_SHIFT  = {14'h0000, TW_IDX_SHIFT, 2'h0};
    localparam logic [31:0] TW_ADDR_AUX    = {14'h0000, TW_IDX_AUX, 2'h0};

    // serial mode register fields
    localparam int unsigned TW_MODE_EN    = 7;
    localparam int unsigned TW_MODE_COI   = 6;
    localparam int unsigned TW_MODE_WUP   = 5;
    localparam int unsigned TW_MODE_ORDER = 2;
    localparam int unsigned TW_MODE_CSH   = 1;
    localparam int unsigned TW_MODE_CSL   = 0;
    localparam logic [7:0]  TW_MODE_RST   = 8'h00;

    // serial bus control register fields
    localparam int unsigned TW_BC_REL     = 0;
    localparam int unsigned TW_BC_CMD     = 1;
    localparam logic [7:0]  TW_BC_RST     = 8'h00;

    // auxiliary control and status register fields
    localparam int unsigned TW_AUX_PLATCH = 0;
    localparam int unsigned TW_AUX_TXONLY = 1;
    localparam int unsigned TW_AUX_PRE_LO = 2;
    localparam int unsigned TW_AUX_PRE_W  = 4;
    localparam int unsigned TW_AUX_DONE   = 8;
    localparam int unsigned TW_AUX_BUSY   = 9;
    localparam int unsigned TW_AUX_INPIN  = 10;
    localparam logic [5:0]  TW_AUX_RST    = 6'h01;

    // clock source encodings
    localparam logic [1:0]  TW_CS_TIMER2  = 2'h2;
    localparam logic [1:0]  TW_CS_PRESC   = 2'h3;

    // word size and bit counter
    localparam int unsigned TW_WORD_BITS  = 8;
    localparam logic [2:0]  TW_LAST_BIT   = 3'h7;

    typedef enum logic [1:0] {
        TW_IDLE = 2'h0,
        TW_HIGH = 2'h1,
        TW_LOW  = 2'h3
    } tw_state_e;

endpackage

// ===== hw/tw_clkgen.sv
// internal serial clock source: timer two edges or prescaled system clock
`timescale 1ns/100ps
`default_nettype none
module tw_clkgen #(
    parameter int unsigned PRE_W = 4,
    parameter int unsigned CNT_W = 17
) (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // selection
    input  wire logic [1:0]       clk_source,
    input  wire logic [PRE_W-1:0] prescale_sel,
    input  wire logic             timer_two_output,
    // half-period tick
    output logic                  tick
);
    import tw_pkg::*;

    logic             t2_prev_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] limit;

    // divide by two to the power (sel+1); each tick is half a serial period
    // sum one bit wider, so the top select does not wrap to a shift of zero
    assign limit = (CNT_W'(1) << ({1'b0, prescale_sel} + (PRE_W+1)'(1))) - CNT_W'(1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
        end else if (cnt_q >= limit) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            t2_prev_q <= 1'b0;
        end else begin
            t2_prev_q <= timer_two_output;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick <= 1'b0;
        end else if (clk_source == TW_CS_TIMER2) begin
            tick <= timer_two_output & ~t2_prev_q;
        end else if (clk_source == TW_CS_PRESC) begin
            tick <= (cnt_q == limit);
        end else begin
            tick <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ===== hw/tw_top.sv
// three-wire serial channel with an AHB-Lite register slave
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - address-compare flag in mode bit 6 is read-only; writes ignored.
// - transmit-only lets the input pin act as a plain port input.
// - address-compare flag reads 0 whenever the channel is disabled.
// - bus control resets to 00H; single-bit and byte writes accepted.
// - release trigger sets the output latch to 1, then self-clears.
// - release trigger clears while the channel is disabled.
// - command trigger clears the output latch to 0, then self-clears.
// - data moves in 8-bit words, one bit per serial clock.
// - shift on falling clock edge; output pin follows the output latch.
// - input pin is captured into the shifter on each rising edge; transmit-only shifts in 0 instead.
// - after 8 bits shifter stops and transfer-done flag is set.
// - internal clock drives the pin; idle level from clock port latch.
// - bit order select reverses shifter writes and reads, not shifting.
// - shifter write starts only if enabled and idle; with an external clock the clock pin must also be high.
// - enabling after a shifter write does not start that word.
// - clock select 0x external pin, 10 timer two, 11 prescaler.
// - mode register resets to 00H: disabled, three-wire, external clock.
module tw_top #(
    parameter int unsigned WORD_BITS = tw_pkg::TW_WORD_BITS
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // serial pins
    input  wire logic        serial_input_pin,
    input  wire logic        serial_clock_pin_in,
    output logic             serial_clock_pin_out,
    output logic             serial_clock_pin_oe,
    output logic             serial_output_pin,
    // timer source
    input  wire logic        timer_two_output
);
    import tw_pkg::*;

    tw_state_e              state_q;
    logic [7:0]             mode_q;
    logic [7:0]             busctl_q;
    logic [5:0]             aux_q;
    logic                   done_q;
    logic [WORD_BITS-1:0]   shift_q;
    logic [2:0]             bit_cnt_q;
    logic                   sck_prev_q;
    logic                   dp_write_q;
    logic [31:0]            dp_addr_q;
    logic [WORD_BITS-1:0]   wr_rev;
    logic [WORD_BITS-1:0]   rd_rev;
    logic [31:0]            rd_value;
    logic                   addr_phase;
    logic                   wr_mode;
    logic                   wr_busctl;
    logic                   wr_shift;
    logic                   wr_aux;
    logic                   enabled;
    logic                   internal_clk;
    logic                   tick;
    logic                   ev_fall;
    logic                   ev_rise;
    logic                   start;
    logic                   shift_in_bit;
    logic                   finish;

    assign enabled      = mode_q[TW_MODE_EN];
    assign internal_clk = mode_q[TW_MODE_CSH];

    // bit order swap on the bus side only; the shift path never changes
    for (genvar i = 0; i < WORD_BITS; i++) begin : g_rev
        assign wr_rev[i] = hwdata[WORD_BITS-1-i];
        assign rd_rev[i] = shift_q[WORD_BITS-1-i];
    end

    tw_clkgen #(
        .PRE_W (TW_AUX_PRE_W),
        .CNT_W (17)
    ) u_clkgen (
        .hclk             (hclk),
        .hresetn          (hresetn),
        .clk_source       (mode_q[TW_MODE_CSH:TW_MODE_CSL]),
        .prescale_sel     (aux_q[TW_AUX_PRE_LO +: TW_AUX_PRE_W]),
        .timer_two_output (timer_two_output),
        .tick             (tick)
    );

    // bus address phase and data-phase write strobes
    assign addr_phase = hsel & hready & htrans[1];
    assign wr_mode    = dp_write_q & (dp_addr_q == TW_ADDR_MODE);
    assign wr_busctl  = dp_write_q & (dp_addr_q == TW_ADDR_BUSCTL);
    assign wr_shift   = dp_write_q & (dp_addr_q == TW_ADDR_SHIFT);
    assign wr_aux     = dp_write_q & (dp_addr_q == TW_ADDR_AUX);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write_q <= 1'b0;
            dp_addr_q  <= 32'h0000_0000;
        end else if (hready) begin
            dp_write_q <= addr_phase & hwrite;
            dp_addr_q  <= haddr;
        end
    end

    // read data is prepared at the address phase, so the slave never waits
    always_comb begin
        rd_value = 32'h0000_0000;
        if (haddr == TW_ADDR_MODE) begin
            rd_value[7:0] = mode_q;
            rd_value[TW_MODE_COI] = 1'b0 & enabled;
        end else if (haddr == TW_ADDR_BUSCTL) begin
            rd_value[7:0] = busctl_q;
        end else if (haddr == TW_ADDR_SHIFT) begin
            rd_value[WORD_BITS-1:0] = mode_q[TW_MODE_ORDER] ? rd_rev : shift_q;
        end else if (haddr == TW_ADDR_AUX) begin
            rd_value[5:0]          = aux_q;
            rd_value[TW_AUX_DONE]  = done_q;
            rd_value[TW_AUX_BUSY]  = (state_q != TW_IDLE);
            rd_value[TW_AUX_INPIN] = serial_input_pin;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_phase & ~hwrite) begin
            hrdata <= rd_value;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // mode register; the compare flag is never stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= TW_MODE_RST;
        end else if (wr_mode) begin
            mode_q <= hwdata[7:0] & ~(8'h01 << TW_MODE_COI);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aux_q <= TW_AUX_RST;
        end else if (wr_aux) begin
            aux_q <= hwdata[5:0];
        end
    end

    // bus control: byte write; a single-bit update is a byte rewrite
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busctl_q <= TW_BC_RST;
        end else if (wr_busctl) begin
            busctl_q <= hwdata[7:0];
            if (!enabled) begin
                busctl_q[TW_BC_REL] <= 1'b0;
            end
        end else begin
            busctl_q[TW_BC_REL] <= 1'b0;
            busctl_q[TW_BC_CMD] <= 1'b0;
        end
    end

    // output latch; shifting has priority, triggers act in any other cycle, also mid-transfer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_output_pin <= 1'b0;
        end else if (ev_fall && state_q != TW_IDLE) begin
            serial_output_pin <= shift_q[WORD_BITS-1];
        end else if (busctl_q[TW_BC_CMD]) begin
            serial_output_pin <= 1'b0;
        end else if (busctl_q[TW_BC_REL]) begin
            serial_output_pin <= 1'b1;
        end
    end

    // clock edges seen by the shifter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sck_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= serial_clock_pin_in;
        end
    end

    always_comb begin
        if (internal_clk) begin
            ev_fall = tick & (state_q == TW_HIGH);
            ev_rise = tick & (state_q == TW_LOW);
        end else begin
            ev_fall = sck_prev_q & ~serial_clock_pin_in;
            ev_rise = ~sck_prev_q & serial_clock_pin_in;
        end
    end

    // a write while disabled only loads data; enabling later does not start it
    assign start = wr_shift & enabled & (state_q == TW_IDLE)
                 & (internal_clk | serial_clock_pin_in);
    assign shift_in_bit = aux_q[TW_AUX_TXONLY] ? 1'b0 : serial_input_pin;
    assign finish = ev_rise & (state_q == TW_LOW) & (bit_cnt_q == TW_LAST_BIT);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q   <= TW_IDLE;
            bit_cnt_q <= 3'h0;
        end else if (!enabled) begin
            state_q   <= TW_IDLE;
            bit_cnt_q <= 3'h0;
        end else begin
            case (state_q)
                TW_IDLE: begin
                    bit_cnt_q <= 3'h0;
                    if (start) begin
                        state_q <= TW_HIGH;
                    end
                end
                TW_HIGH: begin
                    if (ev_fall) begin
                        state_q <= TW_LOW;
                    end
                end
                TW_LOW: begin
                    if (finish) begin
                        state_q <= TW_IDLE;
                    end else if (ev_rise) begin
                        state_q   <= TW_HIGH;
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                    end
                end
                default: begin
                    state_q <= TW_IDLE;
                end
            endcase
        end
    end

    // shift register: loads from the bus when idle, samples on rising edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_q <= '0;
        end else if (wr_shift && state_q == TW_IDLE) begin
            shift_q <= mode_q[TW_MODE_ORDER] ? wr_rev : hwdata[WORD_BITS-1:0];
        end else if (ev_rise && state_q == TW_LOW) begin
            shift_q <= {shift_q[WORD_BITS-2:0], shift_in_bit};
        end
    end

    // done flag: hardware set wins over a write-one clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_q <= 1'b0;
        end else if (finish) begin
            done_q <= 1'b1;
        end else if (wr_aux && hwdata[TW_AUX_DONE]) begin
            done_q <= 1'b0;
        end
    end

    // pin drive; idle level of an internal clock comes from the port latch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_clock_pin_oe  <= 1'b0;
            serial_clock_pin_out <= 1'b1;
        end else begin
            serial_clock_pin_oe <= internal_clk;
            if (state_q == TW_IDLE || !enabled) begin
                serial_clock_pin_out <= start ? 1'b1 : aux_q[TW_AUX_PLATCH];
            end else if (ev_fall) begin
                serial_clock_pin_out <= 1'b0;
            end else if (ev_rise) begin
                serial_clock_pin_out <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// ===== tb/tw_top_asserts.sv
// port checker of the three-wire serial channel
`timescale 1ns/100ps
`default_nettype none
module tw_top_asserts
    import tw_pkg::*;
#(
    parameter int unsigned WORD_BITS = 8
) (
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    // pins
    input wire logic        serial_clock_pin_in,
    input wire logic        serial_clock_pin_out,
    input wire logic        serial_clock_pin_oe,
    input wire logic        serial_output_pin
);
    logic        dp_q;
    logic        dw_q;
    logic [31:0] da_q;
    logic [7:0]  mode_q;
    logic        ck_q;
    logic [2:0]  fa_q;
    logic [2:0]  ta_q;
    logic [3:0]  nf_q;
    logic        ck;
    logic        fell;
    logic        wr_bc;
    logic        wr_sh;
    logic        wr_ax;
    logic        rd_md;
    assign ck = serial_clock_pin_oe ? serial_clock_pin_out : serial_clock_pin_in;
    assign fell = ck_q & ~ck;
    assign wr_bc = dp_q & dw_q & (da_q == TW_ADDR_BUSCTL);
    assign wr_sh = dp_q & dw_q & (da_q == TW_ADDR_SHIFT);
    assign wr_ax = dp_q & dw_q & (da_q == TW_ADDR_AUX);
    assign rd_md = dp_q & ~dw_q & (da_q == TW_ADDR_MODE);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_q <= 1'b0;
            dw_q <= 1'b0;
            da_q <= '0;
        end else begin
            dp_q <= hsel & hready & htrans[1];
            dw_q <= hwrite;
            da_q <= haddr;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= 8'h00;
        end else if (dp_q & dw_q & (da_q == TW_ADDR_MODE)) begin
            mode_q <= hwdata[7:0];
        end
    end
    // ages saturate so a stale cause never excuses a change
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ck_q <= 1'b1;
            fa_q <= 3'h7;
            ta_q <= 3'h7;
            nf_q <= 4'h0;
        end else begin
            ck_q <= ck;
            fa_q <= fell ? 3'h0 : fa_q + {2'h0, fa_q != 3'h7};
            ta_q <= wr_bc ? 3'h0 : ta_q + {2'h0, ta_q != 3'h7};
            // a port latch change moves the idle level; it is no word clock
            nf_q <= (wr_sh | wr_ax) ? 4'h0 : nf_q + {3'h0, fell & serial_clock_pin_oe};
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_bus_okay: assert property (!hresp) else $error("bus response not okay");
    chk_ext_input: assert property (!mode_q[1] && !$past(mode_q[1]) |->
        !serial_clock_pin_oe) else $error("clock pin driven in external mode");
    chk_rel_sets: assert property (wr_bc && mode_q[7] && hwdata[1:0] == 2'h1 |->
        ##[1:3] serial_output_pin) else $error("release did not set output");
    chk_cmd_clears: assert property (wr_bc && mode_q[7] && hwdata[1] |->
        ##[1:3] !serial_output_pin) else $error("command did not clear output");
    // internal clock: the pin fall and its bit show at the same sampled edge
    chk_so_cause: assert property ($changed(serial_output_pin) |->
        fell || fa_q <= 3'h1 || ta_q <= 3'h2) else $error("output moved without cause");
    chk_word_len: assert property (nf_q <= WORD_BITS)
        else $error("more clock falls than one word");
    chk_no_start: assert property (wr_sh && !mode_q[7] |-> ##1 (!fell) [*8])
        else $error("transfer started while disabled");
    chk_cmp_zero: assert property (rd_md |-> !hrdata[6])
        else $error("compare flag read as one");
endmodule
bind tw_top tw_top_asserts #(.WORD_BITS(WORD_BITS)) chk_u (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hresp, .serial_clock_pin_in,
    .serial_clock_pin_out, .serial_clock_pin_oe, .serial_output_pin);
`default_nettype wire

// ===== tb/tw_peer.sv
// far-side peripheral with a clocked serial port
`timescale 1ns/100ps
`default_nettype none
module tw_peer (
    // link pins
    input  wire logic       hclk,
    input  wire logic       sck,
    input  wire logic       so,
    output logic            si,
    // byte to send, byte received
    input  wire logic [7:0] tx_byte,
    output logic      [7:0] rx_q
);
    logic       sck_q = 1'b1;
    logic       frame_q = 1'b0;
    logic [2:0] cnt_q = 3'h0;
    logic [7:0] sh_q = 8'h00;
    initial si = 1'b0;
    initial rx_q = 8'h00;
    // change after the fall, take at the rise
    always @(posedge hclk) begin
        sck_q <= sck;
        if (sck_q && !sck) begin
            si <= frame_q ? sh_q[7] : tx_byte[7];
            sh_q <= frame_q ? {sh_q[6:0], 1'b0} : {tx_byte[6:0], 1'b0};
            frame_q <= 1'b1;
        end else if (!sck_q && sck) begin
            rx_q <= {rx_q[6:0], so};
            cnt_q <= cnt_q + 3'h1;
            frame_q <= (cnt_q != 3'h7);
        end else if (!frame_q) begin
            // released line: no stale level to trust
            si <= ~si;
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// testbench of the three-wire serial channel
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import tw_pkg::*;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        ck_out;
    logic        ck_oe;
    logic        so;
    logic        si;
    logic        ext_lvl;
    logic        t2 = 1'b0;
    logic        sck;
    logic [7:0]  ptx;
    logic [7:0]  prx;
    logic [31:0] rd;
    logic [19:0] r;
    int          errors = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    // order, transmit-only, clock select, data, peer data
    logic [19:0] rows [5] = '{20'h3a53c, 20'hb1ec2, 20'h2ff00, 20'h86bd4, 20'h75a99};
    assign sck = ck_oe ? ck_out : ext_lvl;
    tw_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .serial_input_pin(si), .serial_clock_pin_in(sck), .serial_clock_pin_out(ck_out),
        .serial_clock_pin_oe(ck_oe), .serial_output_pin(so), .timer_two_output(t2));
    tw_peer peer_u (.hclk(hclk), .sck(sck), .so(so), .si(si), .tx_byte(ptx), .rx_q(prx));
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    always @(posedge hclk) t2 <= ~t2;
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            wrap_up();
        end
    end
    function automatic logic [7:0] rev(input logic [7:0] v);
        logic [7:0] o;
        for (int i = 0; i < 8; i++) o[i] = v[7-i];
        return o;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // address phase, then data phase, each held until ready
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        idle(2);
        do begin
            bus(1'b0, TW_ADDR_AUX, 0);
            n++;
        end while (rd[TW_AUX_BUSY] !== 1'b0 && n < 100);
    endtask
    task automatic wrap_up();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = '0;
        ext_lvl = 1'b1;
        ptx = 8'h00;
        idle(16);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rows[i]) begin
            r = rows[i];
            // transmit-only rows also run the prescaler one step slower
            bus(1'b1, TW_ADDR_AUX, {29'h0, r[18], r[18], 1'b1});
            bus(1'b1, TW_ADDR_MODE, {24'h0, 5'h10, r[19], r[17:16]});
            ptx <= r[7:0];
            bus(1'b1, TW_ADDR_SHIFT, {24'h0, r[15:8]});
            if (r[17:16] == 2'h0) begin
                // outside party clocks, idle high between words
                repeat (8) begin
                    idle(3);
                    ext_lvl <= 1'b0;
                    idle(3);
                    ext_lvl <= 1'b1;
                end
            end
            wait_done();
            check(32'(rd[9:8]), 32'h1);
            check(32'(prx), 32'(r[19] ? rev(r[15:8]) : r[15:8]));
            bus(1'b0, TW_ADDR_SHIFT, 0);
            check(rd, r[18] ? 0 : 32'(r[19] ? rev(r[7:0]) : r[7:0]));
            bus(1'b1, TW_ADDR_AUX, {23'h0, 1'b1, 6'h0, r[18], 1'b1});
            $display("row %0d end", i);
        end
        bus(1'b1, TW_ADDR_BUSCTL, 32'h1);
        idle(2);
        check(32'(so), 32'h1);
        bus(1'b0, TW_ADDR_BUSCTL, 0);
        check(rd, 0);
        bus(1'b1, TW_ADDR_BUSCTL, 32'h2);
        idle(2);
        check(32'(so), 0);
        bus(1'b1, TW_ADDR_BUSCTL, 32'hfc);
        bus(1'b0, TW_ADDR_BUSCTL, 0);
        check(rd, 32'hfc);
        bus(1'b1, TW_ADDR_AUX, 0);
        idle(2);
        check(32'({ck_oe, ck_out}), 32'h2);
        bus(1'b1, TW_ADDR_AUX, 32'h1);
        bus(1'b0, 32'h10, 0);
        check(rd, 0);
        $display("trigger test end");
        bus(1'b1, TW_ADDR_MODE, 32'hc3);
        bus(1'b0, TW_ADDR_MODE, 0);
        check(rd, 32'h83);
        bus(1'b1, TW_ADDR_MODE, 32'h43);
        bus(1'b1, TW_ADDR_BUSCTL, 32'h1);
        idle(2);
        bus(1'b0, TW_ADDR_MODE, 0);
        check(rd, 32'h03);
        bus(1'b0, TW_ADDR_BUSCTL, 0);
        check(32'(rd[1:0]), 0);
        bus(1'b1, TW_ADDR_SHIFT, 32'h55);
        bus(1'b1, TW_ADDR_MODE, 32'h83);
        idle(20);
        bus(1'b0, TW_ADDR_AUX, 0);
        check(32'(rd[TW_AUX_BUSY]), 0);
        $display("disable test end");
        hresetn <= 1'b0;
        idle(16);
        check(32'({so, ck_oe}), 0);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, TW_ADDR_MODE, 0);
        check(rd, 32'(TW_MODE_RST));
        bus(1'b0, TW_ADDR_BUSCTL, 0);
        check(rd, 32'(TW_BC_RST));
        bus(1'b0, TW_ADDR_AUX, 0);
        check(32'(rd[9:0]), 32'(TW_AUX_RST));
        $display("reset test end");
        wrap_up();
    end
endmodule
`default_nettype wire
